// file: rtl/fault_auto_restart_ctrl.sv
/*
 * automatic restart controller: acknowledges drive faults and switches the
 * motor on again according to the selected restart mode, with attempt
 * counting, attempt wait, restart monitoring and counter-reset window.
 * assumes: apb master on pclk; drive sequencer inputs synchronous to pclk;
 * fault_in is a level held while a fault is pending.
 */
// Overview of operation
// - mode resets to 0: no ack, no restart
// - mode 1 acknowledges faults, never restarts
// - mode 4 restarts after power failure once
// - mode 6 retries after fault within counter
// - mode 14 restarts power failure after manual ack
// - mode 16 restarts fault after manual ack
// - mode 26 acknowledges all, restarts on switch-on
// - success: one second fault-free after magnetization
// - limit resets to 3, used in restart modes
// - each retry from prove back to wait decrements the attempt counter
// - limit 0 or 1 gives one attempt
// - limit n gives n attempts then fails in modes 6 and 26
// - counter reloads on window, stop+ack, setting write
// - wait time before attempt, 1.0 s default
// - monitor timer 60 s, expiry raises failure
// - monitor time zero disables monitoring
// - counter-reset window starts at each success
// - too many successes in window fail restart
// - auto ack per mode and switch-on
// - auto switch-on only in restart modes
`timescale 1ns/1ps
`include "restart_ctrl_map.svh"
`default_nettype none

module fault_auto_restart_ctrl #(
    parameter int TICK_CYCLES = `RC_TICK_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fault_in,
    input  wire logic        power_fail_in,
    input  wire logic        switch_on_cmd,
    input  wire logic        magnetization_done,
    input  wire logic        manual_ack,
    output logic             auto_ack,
    output logic             restart_on_req,
    output logic             restart_failed_fault
);

    // refuse a tick shorter than the compare logic can serve
    if (TICK_CYCLES < 2) begin : g_tick_check
        $error("TICK_CYCLES must be at least 2");
    end

    // ***************************************************************
    // apb slave
    // ***************************************************************
    logic        wr_en;
    logic        addr_ok;
    logic [7:0]  restart_mode_sel;
    logic [7:0]  attempt_limit;
    logic [15:0] attempt_wait_time;
    logic [15:0] restart_monitor_time;
    logic [15:0] counter_reset_time;
    logic        setting_written;

    assign addr_ok = (paddr == `RC_OFS_MODE) || (paddr == `RC_OFS_LIMIT)
                  || (paddr == `RC_OFS_WAIT) || (paddr == `RC_OFS_MONITOR)
                  || (paddr == `RC_OFS_CNT_RESET) || (paddr == `RC_OFS_STATUS);
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign pready  = psel && penable;
    assign pslverr = psel && penable && !addr_ok;

    assign setting_written = wr_en
        && ((paddr == `RC_OFS_MODE) || (paddr == `RC_OFS_LIMIT));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_mode_sel     <= `RC_RST_MODE;
            attempt_limit        <= `RC_RST_LIMIT;
            attempt_wait_time    <= `RC_RST_WAIT;
            restart_monitor_time <= `RC_RST_MONITOR;
            counter_reset_time   <= `RC_RST_CNT_RESET;
        end else if (wr_en) begin
            unique case (paddr)
                `RC_OFS_MODE:      restart_mode_sel     <= pwdata[7:0];
                `RC_OFS_LIMIT:     attempt_limit        <= pwdata[7:0];
                `RC_OFS_WAIT:      attempt_wait_time    <= pwdata[15:0];
                `RC_OFS_MONITOR:   restart_monitor_time <= pwdata[15:0];
                `RC_OFS_CNT_RESET: counter_reset_time   <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // ***************************************************************
    // mode decode
    // ***************************************************************
    logic mode_restart;
    logic mode_wait;
    logic mode_manual;
    logic mode_ack_always;
    logic mode_ack_on;
    logic mode_retry;
    logic cause_ok;

    always_comb begin
        mode_restart    = 1'b0;
        mode_wait       = 1'b0;
        mode_manual     = 1'b0;
        mode_ack_always = 1'b0;
        mode_ack_on     = 1'b0;
        mode_retry      = 1'b0;
        unique case (restart_mode_sel)
            restart_ctrl_pkg::MODE_ACK_ONLY: mode_ack_always = 1'b1;
            restart_ctrl_pkg::MODE_PF_RESTART: begin
                mode_restart = 1'b1;
                mode_wait    = 1'b1;
                mode_ack_on  = 1'b1;
            end
            restart_ctrl_pkg::MODE_FLT_RETRY: begin
                mode_restart = 1'b1;
                mode_wait    = 1'b1;
                mode_ack_on  = 1'b1;
                mode_retry   = 1'b1;
            end
            restart_ctrl_pkg::MODE_PF_MANUAL,
            restart_ctrl_pkg::MODE_FLT_MANUAL: begin
                mode_restart = 1'b1;
                mode_manual  = 1'b1;
            end
            restart_ctrl_pkg::MODE_ALL: begin
                mode_restart    = 1'b1;
                mode_wait       = 1'b1;
                mode_ack_always = 1'b1;
                mode_retry      = 1'b1;
            end
            // mode 0 and unknown codes do nothing
            default: ;
        endcase
    end

    // power-failure modes only restart after power failures
    assign cause_ok = (restart_mode_sel == restart_ctrl_pkg::MODE_PF_RESTART
                    || restart_mode_sel == restart_ctrl_pkg::MODE_PF_MANUAL)
                    ? power_fail_in : 1'b1;

    // ***************************************************************
    // time base
    // ***************************************************************
    logic [31:0] prescale_reg;
    logic        tick;

    assign tick = (prescale_reg == 32'(TICK_CYCLES - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_reg <= 32'h0000_0000;
        end else if (tick) begin
            prescale_reg <= 32'h0000_0000;
        end else begin
            prescale_reg <= prescale_reg + 32'h0000_0001;
        end
    end

    // ***************************************************************
    // sequencer
    // ***************************************************************
    restart_ctrl_pkg::restart_state_t state_reg;
    restart_ctrl_pkg::restart_state_t state_next;
    logic [15:0] step_tmr_reg;
    logic [15:0] mon_tmr_reg;
    logic        mon_run_reg;
    logic [15:0] win_tmr_reg;
    logic        win_run_reg;
    logic [7:0]  attempt_cnt_reg;
    logic [7:0]  success_cnt_reg;
    logic [7:0]  limit_eff;
    logic        do_ack;
    logic        ack_ok;
    logic        success;
    logic        mon_expired;
    logic        win_expired;
    logic        too_many;
    logic        attempts_gone;
    logic        fail_set;
    logic        fail_clear;

    assign limit_eff = (attempt_limit == 8'h00) ? 8'h01 : attempt_limit;

    assign do_ack = fault_in && !restart_failed_fault
        && (mode_ack_always || (mode_ack_on && switch_on_cmd));
    // manual modes wait for the operator acknowledgement
    assign ack_ok = mode_manual ? manual_ack : do_ack;
    assign auto_ack = do_ack;

    assign success = (state_reg == restart_ctrl_pkg::ST_PROVE) && !fault_in
        && magnetization_done && tick && (step_tmr_reg >= `RC_SUCCESS_TICKS - 16'h0001);

    assign mon_expired = mon_run_reg && (restart_monitor_time != 16'h0000)
        && tick && (mon_tmr_reg >= restart_monitor_time - 16'h0001);
    assign win_expired = win_run_reg && tick
        && (win_tmr_reg >= counter_reset_time - 16'h0001);
    assign too_many = success && win_run_reg && (success_cnt_reg >= limit_eff);
    assign attempts_gone = (state_reg == restart_ctrl_pkg::ST_PROVE) && fault_in
        && (attempt_cnt_reg == 8'h00 || !mode_retry);
    assign fail_set = mode_restart && (mon_expired || too_many || attempts_gone);
    // cleared by ack with switch-on low
    assign fail_clear = manual_ack && !switch_on_cmd;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            restart_ctrl_pkg::ST_IDLE: begin
                if (mode_restart && fault_in && cause_ok && ack_ok && switch_on_cmd) begin
                    state_next = restart_ctrl_pkg::ST_WAIT;
                end
            end
            restart_ctrl_pkg::ST_WAIT: begin
                // wait before attempt, modes 4/6/26 only
                if (!switch_on_cmd) begin
                    state_next = restart_ctrl_pkg::ST_IDLE;
                end else if (!mode_wait || (tick && step_tmr_reg >= attempt_wait_time)) begin
                    state_next = restart_ctrl_pkg::ST_START;
                end
            end
            restart_ctrl_pkg::ST_START: begin
                if (magnetization_done) begin
                    state_next = restart_ctrl_pkg::ST_PROVE;
                end
            end
            restart_ctrl_pkg::ST_PROVE: begin
                if (success) begin
                    state_next = restart_ctrl_pkg::ST_IDLE;
                end else if (fault_in && mode_retry && ack_ok) begin
                    state_next = restart_ctrl_pkg::ST_WAIT;
                end else if (fault_in) begin
                    state_next = restart_ctrl_pkg::ST_IDLE;
                end
            end
            restart_ctrl_pkg::ST_FAILED: begin
                if (fail_clear) begin
                    state_next = restart_ctrl_pkg::ST_IDLE;
                end
            end
            default: state_next = restart_ctrl_pkg::ST_IDLE;
        endcase
        if (fail_set) begin
            state_next = restart_ctrl_pkg::ST_FAILED;
        end
        if (!mode_restart && state_reg != restart_ctrl_pkg::ST_FAILED) begin
            state_next = restart_ctrl_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= restart_ctrl_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // step timer restarts on each state change
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_tmr_reg <= 16'h0000;
        end else if (state_next != state_reg) begin
            step_tmr_reg <= 16'h0000;
        end else if (tick && step_tmr_reg != 16'hFFFF) begin
            step_tmr_reg <= step_tmr_reg + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon_run_reg <= 1'b0;
            mon_tmr_reg <= 16'h0000;
        end else if (success || fail_set || !mode_restart) begin
            mon_run_reg <= 1'b0;
            mon_tmr_reg <= 16'h0000;
        end else if (fault_in && !mon_run_reg && state_reg != restart_ctrl_pkg::ST_FAILED) begin
            mon_run_reg <= 1'b1;
            mon_tmr_reg <= 16'h0000;
        end else if (mon_run_reg && tick) begin
            mon_tmr_reg <= mon_tmr_reg + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_run_reg     <= 1'b0;
            win_tmr_reg     <= 16'h0000;
            success_cnt_reg <= 8'h00;
        end else if (success) begin
            win_run_reg     <= (counter_reset_time != 16'h0000);
            win_tmr_reg     <= 16'h0000;
            success_cnt_reg <= win_run_reg ? success_cnt_reg + 8'h01 : 8'h01;
        end else if (win_expired) begin
            win_run_reg     <= 1'b0;
            success_cnt_reg <= 8'h00;
        end else if (win_run_reg && tick) begin
            win_tmr_reg <= win_tmr_reg + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            attempt_cnt_reg <= `RC_RST_LIMIT - 8'h01;
        end else if (setting_written || (success && counter_reset_time == 16'h0000)
                     || win_expired || (restart_failed_fault && fail_clear)) begin
            attempt_cnt_reg <= limit_eff - 8'h01;
        end else if (state_reg == restart_ctrl_pkg::ST_PROVE
                     && state_next == restart_ctrl_pkg::ST_WAIT
                     && attempt_cnt_reg != 8'h00) begin
            attempt_cnt_reg <= attempt_cnt_reg - 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_failed_fault <= 1'b0;
        end else if (fail_set) begin
            restart_failed_fault <= 1'b1;
        end else if (fail_clear) begin
            restart_failed_fault <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_on_req <= 1'b0;
        end else begin
            restart_on_req <= switch_on_cmd && mode_restart
                && (state_next == restart_ctrl_pkg::ST_START
                 || state_next == restart_ctrl_pkg::ST_PROVE);
        end
    end

    // ***************************************************************
    // read data
    // ***************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `RC_OFS_MODE:      prdata <= {24'h000000, restart_mode_sel};
                `RC_OFS_LIMIT:     prdata <= {24'h000000, attempt_limit};
                `RC_OFS_WAIT:      prdata <= {16'h0000, attempt_wait_time};
                `RC_OFS_MONITOR:   prdata <= {16'h0000, restart_monitor_time};
                `RC_OFS_CNT_RESET: prdata <= {16'h0000, counter_reset_time};
                `RC_OFS_STATUS:    prdata <= {16'h0000, attempt_cnt_reg, 1'b0,
                                              state_reg, 1'b0, auto_ack,
                                              restart_on_req, restart_failed_fault};
                default:           prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

`default_nettype wire

// file: rtl/restart_ctrl_map.svh
/*
 * register offsets, field positions, reset values and timing figures of the
 * automatic restart controller.
 * assumes: included by the design file and the test files by its bare name.
 */
`ifndef RESTART_CTRL_MAP_SVH
`define RESTART_CTRL_MAP_SVH

// ***************************************************************
// register offsets (byte addresses)
// ***************************************************************
`define RC_OFS_MODE        12'h000
`define RC_OFS_LIMIT       12'h004
`define RC_OFS_WAIT        12'h008
`define RC_OFS_MONITOR     12'h00C
`define RC_OFS_CNT_RESET   12'h010
`define RC_OFS_STATUS      12'h014

// ***************************************************************
// reset values (times in 10 ms ticks)
// ***************************************************************
`define RC_RST_MODE        8'h00
`define RC_RST_LIMIT       8'h03
`define RC_RST_WAIT        16'h0064
`define RC_RST_MONITOR     16'h1770
`define RC_RST_CNT_RESET   16'h0000

// ***************************************************************
// timing
// ***************************************************************
`define RC_TICK_NS         10000000
`define RC_CLK_NS          4
`define RC_TICK_CYCLES     (`RC_TICK_NS / `RC_CLK_NS)
`define RC_SUCCESS_TICKS   16'h0064

// ***************************************************************
// status field positions
// ***************************************************************
`define RC_ST_FAILED       0
`define RC_ST_ON_REQ       1
`define RC_ST_ACK_REQ      2
`define RC_ST_STATE_LSB    4
`define RC_ST_CNT_LSB      8

`endif

// file: rtl/restart_ctrl_pkg.sv
/*
 * types of the automatic restart controller.
 * assumes: mode and state codes are literals, none come from restart_ctrl_map.svh.
 */
package restart_ctrl_pkg;

    typedef enum logic [7:0] {
        MODE_OFF        = 8'h00,
        MODE_ACK_ONLY   = 8'h01,
        MODE_PF_RESTART = 8'h04,
        MODE_FLT_RETRY  = 8'h06,
        MODE_PF_MANUAL  = 8'h0E,
        MODE_FLT_MANUAL = 8'h10,
        MODE_ALL        = 8'h1A
    } restart_mode_t;

    // gray codes along idle -> wait -> start -> prove
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_WAIT   = 3'b001,
        ST_START  = 3'b011,
        ST_PROVE  = 3'b010,
        ST_FAILED = 3'b110
    } restart_state_t;

endpackage

// file: test/drive_seq_model.sv
/* behavioural drive sequencer: raises faults, follows switch-on requests.
   assumes: testbench commands inject and refault on pclk. */
`timescale 1ns/1ps
`default_nettype none
module drive_seq_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic inject,
    input  wire logic refault,
    input  wire logic ack,
    input  wire logic restart_on_req,
    output logic      fault_in,
    output logic      magnetization_done
);
    int mag_cnt;
    // ***************************************************************
    // fault level and magnetization after switch-on
    // ***************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_in <= 1'b0;
            magnetization_done <= 1'b0;
            mag_cnt <= 0;
        end else begin
            if (inject || (refault && mag_cnt == 22)) begin
                fault_in <= 1'b1;
            end else if (ack) begin
                fault_in <= 1'b0;
            end
            if (restart_on_req && !fault_in) begin
                mag_cnt <= mag_cnt + 1;
                magnetization_done <= (mag_cnt >= 2);
            end else begin
                mag_cnt <= 0;
                magnetization_done <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// file: test/fault_auto_restart_ctrl_tb.sv
/* self-checking bench of the automatic restart controller.
   assumes: short tick (4 cycles); sequencer model on the drive side. */
`timescale 1ns/1ps
`include "restart_ctrl_map.svh"
`default_nettype none
module fault_auto_restart_ctrl_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        fault_in, power_fail_in, switch_on_cmd, magnetization_done, manual_ack;
    logic        auto_ack, restart_on_req, restart_failed_fault, inject, refault;
    int          bad_count = 0;
    int          n_compared = 0;
    fault_auto_restart_ctrl #(.TICK_CYCLES(4)) u_fault_auto_restart_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fault_in(fault_in), .power_fail_in(power_fail_in), .switch_on_cmd(switch_on_cmd),
        .magnetization_done(magnetization_done), .manual_ack(manual_ack), .auto_ack(auto_ack),
        .restart_on_req(restart_on_req), .restart_failed_fault(restart_failed_fault));
    drive_seq_model u_drive_seq_model (
        .pclk(pclk), .presetn(presetn), .inject(inject), .refault(refault),
        .ack(auto_ack | manual_ack), .restart_on_req(restart_on_req), .fault_in(fault_in),
        .magnetization_done(magnetization_done));
    // ***************************************************************
    // bus and compare tasks
    // ***************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic e_err);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(q, exp);
        chk({31'h0, e}, {31'h0, e_err});
    endtask
    task automatic pulse_ack(input logic on);
        @(posedge pclk);
        switch_on_cmd <= on;
        manual_ack <= 1'b1;
        @(posedge pclk);
        manual_ack <= 1'b0;
        switch_on_cmd <= 1'b1;
        @(posedge pclk);
    endtask
    // ***************************************************************
    // scenarios
    // ***************************************************************
    task automatic t_reset;
        rd_chk(`RC_OFS_MODE, 32'h0000_0000, 1'b0);
        rd_chk(`RC_OFS_LIMIT, 32'h0000_0003, 1'b0);
        rd_chk(`RC_OFS_WAIT, 32'h0000_0064, 1'b0);
        rd_chk(`RC_OFS_MONITOR, 32'h0000_1770, 1'b0);
        rd_chk(`RC_OFS_CNT_RESET, 32'h0000_0000, 1'b0);
        rd_chk(`RC_OFS_STATUS, 32'h0000_0200, 1'b0);
        rd_chk(12'h040, 32'h0000_0000, 1'b1);
        $display("reset values done");
    endtask
    task automatic run_row(input logic [7:0] mode, input logic [7:0] lim, input logic [15:0] wt,
                           input logic [15:0] mon, input logic rf, input logic man,
                           input int e_rise, input logic e_ack, input logic e_fail);
        int   rises;
        int   first;
        logic acked;
        logic prev;
        rises = 0;
        first = -1;
        acked = 1'b0;
        prev = 1'b0;
        wr(`RC_OFS_LIMIT, {24'h0, lim});
        wr(`RC_OFS_WAIT, {16'h0, wt});
        wr(`RC_OFS_MONITOR, {16'h0, mon});
        wr(`RC_OFS_MODE, {24'h0, mode});
        @(posedge pclk);
        power_fail_in <= (mode == 8'h04 || mode == 8'h0E);
        refault <= rf;
        inject <= 1'b1;
        for (int i = 0; i < 520; i++) begin
            @(posedge pclk);
            inject <= 1'b0;
            manual_ack <= man && (i == 40);
            if (auto_ack === 1'b1) acked = 1'b1;
            if (restart_on_req === 1'b1 && !prev) begin
                rises++;
                if (first < 0) first = i;
            end
            prev = (restart_on_req === 1'b1);
        end
        refault <= 1'b0;
        chk(32'(rises), 32'(e_rise));
        chk({31'h0, acked}, {31'h0, e_ack});
        chk({30'h0, restart_on_req, restart_failed_fault}, {31'h0, e_fail});
        if (e_rise > 0 && !man) chk({31'h0, first >= 8 && first <= 20}, 32'h1);
        if (e_fail) begin
            pulse_ack(1'b1);
            chk({31'h0, restart_failed_fault}, 32'h0000_0001);
            // operator stops, acknowledges, switches on again
            pulse_ack(1'b0);
            chk({31'h0, restart_failed_fault}, 32'h0000_0000);
            rd_chk(`RC_OFS_STATUS, {16'h0, (lim > 1 ? lim - 8'h01 : 8'h00), 8'h00}, 1'b0);
        end
        $display("episode mode %0d limit %0d done", mode, lim);
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        repeat (40000) @(posedge pclk);
        bad_count++;
        end_of_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {power_fail_in, manual_ack, inject, refault} = '0;
        switch_on_cmd = 1'b1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        run_row(8'h00, 8'h03, 16'h0002, 16'h0000, 1'b0, 1'b1, 0, 1'b0, 1'b0);
        run_row(8'h01, 8'h03, 16'h0002, 16'h0000, 1'b0, 1'b0, 0, 1'b1, 1'b0);
        run_row(8'h04, 8'h03, 16'h0002, 16'h0000, 1'b0, 1'b0, 1, 1'b1, 1'b0);
        run_row(8'h06, 8'h03, 16'h0002, 16'h0000, 1'b0, 1'b0, 1, 1'b1, 1'b0);
        run_row(8'h0E, 8'h03, 16'h0002, 16'h0000, 1'b0, 1'b1, 1, 1'b0, 1'b0);
        run_row(8'h10, 8'h03, 16'h0002, 16'h0000, 1'b0, 1'b1, 1, 1'b0, 1'b0);
        run_row(8'h1A, 8'h03, 16'h0002, 16'h0000, 1'b0, 1'b0, 1, 1'b1, 1'b0);
        run_row(8'h04, 8'h03, 16'h0002, 16'h0000, 1'b1, 1'b0, 1, 1'b1, 1'b1);
        run_row(8'h06, 8'h01, 16'h0002, 16'h0000, 1'b1, 1'b0, 1, 1'b1, 1'b1);
        run_row(8'h06, 8'h00, 16'h0002, 16'h0000, 1'b1, 1'b0, 1, 1'b1, 1'b1);
        run_row(8'h06, 8'h02, 16'h0002, 16'h0000, 1'b1, 1'b0, 2, 1'b1, 1'b1);
        run_row(8'h1A, 8'h03, 16'h0014, 16'h0003, 1'b0, 1'b0, 0, 1'b1, 1'b1);
        end_of_test();
    end
endmodule
`default_nettype wire

// file: test/restart_ctrl_monitor.sv
/* port checker of the automatic restart controller.
   assumes: bound to fault_auto_restart_ctrl; one clock domain. */
`timescale 1ns/1ps
`include "restart_ctrl_map.svh"
`default_nettype none
module restart_ctrl_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        fault_in,
    input wire logic        switch_on_cmd,
    input wire logic        manual_ack,
    input wire logic        auto_ack,
    input wire logic        restart_on_req,
    input wire logic        restart_failed_fault
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] mode_q;
    // ***************************************************************
    // mode shadow from bus writes
    // ***************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 8'h00;
        end else if (psel && penable && pwrite && paddr == `RC_OFS_MODE) begin
            mode_q <= pwdata[7:0];
        end
    end
    sequence s_fail_drop;
        restart_failed_fault ##1 !restart_failed_fault;
    endsequence
    a_off_quiet: assert property (
        mode_q == 8'h00 && $past(mode_q) == 8'h00 |-> !auto_ack && !restart_on_req)
        else $error("mode 0 acted");
    a_ackonly_no_on: assert property (
        mode_q == 8'h01 && $past(mode_q) == 8'h01 |-> !restart_on_req)
        else $error("mode 1 switched on");
    a_always_ack: assert property (
        (mode_q == 8'h01 || mode_q == 8'h1A) && fault_in |-> auto_ack)
        else $error("fault not acknowledged");
    a_manual_no_ack: assert property (
        mode_q == 8'h0E || mode_q == 8'h10 |-> !auto_ack)
        else $error("manual mode acknowledged");
    a_ack_needs_on: assert property (
        (mode_q == 8'h04 || mode_q == 8'h06) && auto_ack |-> switch_on_cmd)
        else $error("ack without switch-on");
    a_on_needs_cmd: assert property (
        $rose(restart_on_req) |-> $past(switch_on_cmd)
        && $past(mode_q) inside {8'h04, 8'h06, 8'h0E, 8'h10, 8'h1A})
        else $error("switch-on request not allowed");
    a_fail_release: assert property (
        s_fail_drop |-> $past(manual_ack && !switch_on_cmd))
        else $error("failure cleared wrongly");
    a_apb_ready: assert property (
        psel |-> pready == penable)
        else $error("pready wrong");
    a_unmapped_err: assert property (
        psel && penable && paddr > `RC_OFS_STATUS |-> pslverr)
        else $error("no error on unmapped");
endmodule
bind fault_auto_restart_ctrl restart_ctrl_monitor u_restart_ctrl_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_in(fault_in), .switch_on_cmd(switch_on_cmd), .manual_ack(manual_ack),
    .auto_ack(auto_ack), .restart_on_req(restart_on_req),
    .restart_failed_fault(restart_failed_fault));
`default_nettype wire
